/* File: wdg_cpu_model.sv */
// processor-side model: watchdog oscillator level, restart and vector pulses
// assumes the bench calls its tasks just after a rising mclk edge
`timescale 1ns/1ps
`default_nettype none

module wdg_cpu_model (
    // system clock
    input  wire logic        mclk,
    // towards the watchdog
    output var  logic        osc_clk,
    output var  logic        restart_req,
    output var  logic        vector_ack,
    // oscillator ticks since the last restart
    output var  logic [31:0] ticks
);
    logic [1:0] div_ff;

    initial begin
        osc_clk = 1'b0;
        restart_req = 1'b0;
        vector_ack = 1'b0;
        ticks = 32'h0000_0000;
        div_ff = 2'h0;
    end

    // free-running oscillator, one tick every four mclk cycles
    always @(posedge mclk) begin
        div_ff <= div_ff + 2'h1;
        osc_clk <= div_ff[1];
        if (restart_req) begin
            ticks <= 32'h0000_0000;
        end else if (!osc_clk && div_ff[1]) begin
            ticks <= ticks + 32'h0000_0001;
        end
    end

    // one-cycle pulse; never call twice in the same time step
    task automatic restart();
        restart_req <= 1'b1;
        @(posedge mclk);
        restart_req <= 1'b0;
    endtask

    task automatic vector();
        vector_ack <= 1'b1;
        @(posedge mclk);
        vector_ack <= 1'b0;
    endtask
endmodule

`default_nettype wire

/* File: wdg_pkg.sv */
// watchdog package: register map, control field layout, state record, period decode
// assumes one system clock; the watchdog oscillator arrives as a synchronous level
`default_nettype none

package wdg_pkg;

    // register byte addresses on the bus
    localparam logic [31:0] ADDR_CTL   = 32'h0000_0000;
    localparam logic [31:0] ADDR_CAUSE = 32'h0000_0004;

    // control/status field positions
    localparam int BIT_FLAG  = 7;
    localparam int BIT_IE    = 6;
    localparam int BIT_P3    = 5;
    localparam int BIT_CE    = 4;
    localparam int BIT_RE    = 3;
    localparam int BIT_P2    = 2;
    localparam int BIT_P0    = 0;
    // reset-cause field position
    localparam int BIT_WATCHDOG_CAUSED_RESET_FLAG  = 3;

    // reset values and the counter step
    localparam logic [3:0]  PSEL_RST   = 4'h0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
    localparam logic [20:0] CNT_ZERO   = 21'h00_0000;
    localparam logic [20:0] CNT_ONE    = 21'h00_0001;

    // unlock window length in system clock cycles
    localparam logic [2:0]  UNLOCK_CYCLES = 3'h4;
    localparam logic [2:0]  UNLOCK_LAST   = 3'h1;
    localparam logic [2:0]  UNLOCK_NONE   = 3'h0;

    // watchdog oscillator and the selectable time-out range
    localparam int OSC_HZ      = 128000;
    localparam int SHORTEST_MS = 1;
    localparam int LONGEST_S   = 8;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic        flag;
        logic        ie;
        logic        re;
        logic [3:0]  psel;
        logic        unlock;
        logic [2:0]  unlock_cnt;
        logic        watchdog_caused_reset_flag;
        logic [20:0] cnt;
        logic        osc_q;
        logic        irq;
        logic        sysrst;
        logic        wr_ctl;
        logic        wr_cause;
        logic [31:0] hrdata;
        logic        hready;
    } wdg_state_s;

    // time-out length in oscillator cycles for each period code
    function automatic logic [20:0] wdg_limit(input logic [3:0] p);
        case (p)
            4'h0:    wdg_limit = 21'h00_0800;
            4'h1:    wdg_limit = 21'h00_1000;
            4'h2:    wdg_limit = 21'h00_2000;
            4'h3:    wdg_limit = 21'h00_4000;
            4'h4:    wdg_limit = 21'h00_8000;
            4'h5:    wdg_limit = 21'h01_0000;
            4'h6:    wdg_limit = 21'h02_0000;
            4'h7:    wdg_limit = 21'h04_0000;
            4'h8:    wdg_limit = 21'h08_0000;
            4'h9:    wdg_limit = 21'h10_0000;
            4'hA:    wdg_limit = 21'h00_0400;
            4'hB:    wdg_limit = 21'h00_0200;
            4'hC:    wdg_limit = 21'h00_0100;
            4'hD:    wdg_limit = 21'h00_0080;
            // reserved codes fall back to the shortest standard setting
            default: wdg_limit = 21'h00_0800;
        endcase
    endfunction

endpackage

`default_nettype wire

/* File: wdg_tb.sv */
// self-checking bench for the watchdog timer over ahb-lite
// assumes zero-wait-state slave; the cpu model supplies oscillator and pulses
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic        mclk, rst, hsel, hwrite, hready_o, hresp, fuse, gie, irq, sys_rst, rst_q;
    logic        osc, rq, va;
    logic [31:0] haddr, hwdata, hrdata, ticks, rst_ticks, q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          errors, checks_done, n_rst, n0, ex;
    logic [3:0]  code;

    wdg_timer u_dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready_o), .hrdata(hrdata),
        .hreadyout(hready_o), .hresp(hresp), .restart_req(rq), .vector_ack(va),
        .global_irq_en(gie), .always_on_fuse(fuse), .osc_clk(osc), .timeout_irq(irq),
        .system_reset(sys_rst));
    wdg_cpu_model u_cpu (.mclk(mclk), .osc_clk(osc), .restart_req(rq), .vector_ack(va), .ticks(ticks));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic ahb(input logic [31:0] a, input logic w, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= wdg_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge mclk); while (hready_o !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        do @(posedge mclk); while (hready_o !== 1'b1);
        q = hrdata;
    endtask

    task automatic rdc(input logic [31:0] a, input logic [7:0] e);
        ahb(a, 1'b0, 8'h00);
        chk(q, {24'h00_0000, e});
        chk({31'h0, hresp}, 32'h0000_0000);
    endtask

    function automatic logic [7:0] enc(input logic [3:0] c);
        return {2'b00, c[3], 2'b01, c[2:0]};
    endfunction

    function automatic int exp_ticks(input logic [3:0] c);
        return (c <= 4'h9) ? (2048 << c) : (1024 >> (c - 4'hA));
    endfunction

    // every reset pulse is counted; a pulse longer than one cycle is a mismatch
    always @(posedge mclk) begin
        rst_q <= sys_rst;
        if (sys_rst === 1'b1) begin
            n_rst <= n_rst + 1;
            rst_ticks <= ticks;
            chk({31'h0, rst_q}, 32'h0000_0000);
        end
    end

    initial begin
        #400_000;
        errors++;
        end_sim();
    end

    initial begin
        {hsel, hwrite, fuse, gie} = 4'h0;
        {haddr, hwdata, htrans, errors, checks_done} = '0;
        hsize = 3'h2;
        rst = 1'b1;
        void'($urandom(32'h494e));
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rdc(wdg_pkg::ADDR_CTL, 8'h00);
        rdc(wdg_pkg::ADDR_CAUSE, 8'h00);
        rdc(32'h0000_0010, 8'h00);
        ahb(wdg_pkg::ADDR_CTL, 1'b1, 8'h2D);
        rdc(wdg_pkg::ADDR_CTL, 8'h08);
        u_cpu.restart();
        ahb(wdg_pkg::ADDR_CTL, 1'b1, 8'h18);
        ahb(wdg_pkg::ADDR_CTL, 1'b1, 8'h2D);
        rdc(wdg_pkg::ADDR_CTL, 8'h2D);
        ahb(wdg_pkg::ADDR_CTL, 1'b1, 8'h18);
        repeat (6) @(posedge mclk);
        ahb(wdg_pkg::ADDR_CTL, 1'b1, 8'h20);
        rdc(wdg_pkg::ADDR_CTL, 8'h2D);
        // reset mode at the shortest period
        n0 = n_rst;
        u_cpu.restart();
        for (int i = 0; i < 600 && n_rst == n0; i++) @(posedge mclk);
        chk({31'h0, rst_ticks >= 127 && rst_ticks <= 129}, 32'h0000_0001);
        rdc(wdg_pkg::ADDR_CAUSE, 8'h08);
        for (int i = 0; i < 600 && n_rst == n0 + 1; i++) @(posedge mclk);
        chk(n_rst, n0 + 2);
        n0 = n_rst;
        repeat (6) begin
            repeat (256) @(posedge mclk);
            u_cpu.restart();
        end
        chk(n_rst, n0);
        ahb(wdg_pkg::ADDR_CAUSE, 1'b1, 8'h00);
        ahb(wdg_pkg::ADDR_CTL, 1'b1, 8'h18);
        ahb(wdg_pkg::ADDR_CTL, 1'b1, 8'h25);
        rdc(wdg_pkg::ADDR_CTL, 8'h25);
        repeat (600) @(posedge mclk);
        chk(n_rst, n0);
        // interrupt mode, global enable off first
        ahb(wdg_pkg::ADDR_CTL, 1'b1, 8'h65);
        u_cpu.restart();
        repeat (530) @(posedge mclk);
        chk({31'h0, irq}, 32'h0000_0000);
        rdc(wdg_pkg::ADDR_CTL, 8'hE5);
        chk(n_rst, n0);
        gie <= 1'b1;
        repeat (3) @(posedge mclk);
        chk({31'h0, irq}, 32'h0000_0001);
        ahb(wdg_pkg::ADDR_CTL, 1'b1, 8'h65);
        rdc(wdg_pkg::ADDR_CTL, 8'hE5);
        ahb(wdg_pkg::ADDR_CTL, 1'b1, 8'hE5);
        rdc(wdg_pkg::ADDR_CTL, 8'h65);
        u_cpu.restart();
        repeat (530) @(posedge mclk);
        u_cpu.vector();
        rdc(wdg_pkg::ADDR_CTL, 8'h65);
        // combined mode: interrupt first, then reset
        ahb(wdg_pkg::ADDR_CTL, 1'b1, 8'h6D);
        u_cpu.restart();
        repeat (530) @(posedge mclk);
        rdc(wdg_pkg::ADDR_CTL, 8'hED);
        chk(n_rst, n0);
        // vector not taken: the next expiry must reset
        repeat (530) @(posedge mclk);
        chk(n_rst, n0 + 1);
        u_cpu.vector();
        rdc(wdg_pkg::ADDR_CTL, 8'h2D);
        u_cpu.restart();
        repeat (530) @(posedge mclk);
        chk(n_rst, n0 + 2);
        fuse <= 1'b1;
        ahb(wdg_pkg::ADDR_CTL, 1'b1, 8'h40);
        rdc(wdg_pkg::ADDR_CTL, 8'h2D);
        fuse <= 1'b0;
        // random short periods, measured in oscillator ticks
        repeat (3) begin
            code = 4'hA + 4'($urandom % 4);
            ex = exp_ticks(code);
            u_cpu.restart();
            ahb(wdg_pkg::ADDR_CTL, 1'b1, 8'h18);
            ahb(wdg_pkg::ADDR_CTL, 1'b1, enc(code));
            rdc(wdg_pkg::ADDR_CTL, enc(code));
            n0 = n_rst;
            u_cpu.restart();
            for (int i = 0; i < ex * 4 + 40 && n_rst == n0; i++) @(posedge mclk);
            chk({31'h0, rst_ticks >= ex - 1 && rst_ticks <= ex + 1}, 32'h0000_0001);
        end
        end_sim();
    end
endmodule

`default_nettype wire

/* File: wdg_timer.sv */
// watchdog timer: counter on oscillator ticks, mode logic, timed unlock, ahb-lite slave
// assumes rst is power-on only; the system reset it raises does not reset this block
`timescale 1ns/1ps
`default_nettype none

module wdg_timer (
    // clock and power-on reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    // processor side
    input  wire logic        restart_req,
    input  wire logic        vector_ack,
    input  wire logic        global_irq_en,
    input  wire logic        always_on_fuse,
    // watchdog oscillator level
    input  wire logic        osc_clk,
    // results
    output var  logic        timeout_irq,
    output var  logic        system_reset
);

    wdg_pkg::wdg_state_s st_ff;
    wdg_pkg::wdg_state_s nxt_st;

    logic        ie_eff;
    logic        re_eff;
    logic        running;
    logic        tick;
    logic        expire;
    logic [20:0] limit;
    logic        addr_ok;
    logic [7:0]  ctl_view;
    logic [7:0]  wbyte;
    logic        unlock_start;
    logic        unlock_write;

    // fuse masks interrupt enable; fuse and cause flag pin reset enable high
    assign ie_eff  = st_ff.ie & ~always_on_fuse;
    assign re_eff  = st_ff.re | always_on_fuse | st_ff.watchdog_caused_reset_flag;
    assign running = ie_eff | re_eff;
    // oscillator is sampled as a synchronous level, one tick per rising edge
    assign tick    = osc_clk & ~st_ff.osc_q;
    assign limit   = wdg_pkg::wdg_limit(st_ff.psel);
    // >= so a shortened period past the count expires at the next oscillator tick
    assign expire  = running & tick & ~restart_req
                   & (st_ff.cnt >= (limit - wdg_pkg::CNT_ONE));

    assign addr_ok = hsel & htrans[1] & hready;
    assign wbyte   = hwdata[7:0];
    assign unlock_start = st_ff.wr_ctl & wbyte[wdg_pkg::BIT_CE] & wbyte[wdg_pkg::BIT_RE];
    assign unlock_write = st_ff.wr_ctl & st_ff.unlock & ~wbyte[wdg_pkg::BIT_CE];

    always_comb begin
        ctl_view = 8'h00;
        ctl_view[wdg_pkg::BIT_FLAG] = st_ff.flag;
        ctl_view[wdg_pkg::BIT_IE]   = ie_eff;
        ctl_view[wdg_pkg::BIT_P3]   = st_ff.psel[3];
        ctl_view[wdg_pkg::BIT_CE]   = st_ff.unlock;
        ctl_view[wdg_pkg::BIT_RE]   = re_eff;
        ctl_view[wdg_pkg::BIT_P2:wdg_pkg::BIT_P0] = st_ff.psel[2:0];
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.osc_q  = osc_clk;
        nxt_st.sysrst = 1'b0;

        // bus address phase: latch write target, prepare read word
        nxt_st.wr_ctl   = addr_ok & hwrite & (haddr == wdg_pkg::ADDR_CTL);
        nxt_st.wr_cause = addr_ok & hwrite & (haddr == wdg_pkg::ADDR_CAUSE);
        nxt_st.hrdata   = wdg_pkg::RDATA_ZERO;
        if (addr_ok & ~hwrite & (haddr == wdg_pkg::ADDR_CTL)) begin
            nxt_st.hrdata[7:0] = ctl_view;
        end else if (addr_ok & ~hwrite & (haddr == wdg_pkg::ADDR_CAUSE)) begin
            nxt_st.hrdata[wdg_pkg::BIT_WATCHDOG_CAUSED_RESET_FLAG] = st_ff.watchdog_caused_reset_flag;
        end
        nxt_st.hready = 1'b1;

        // unlock window countdown
        if (st_ff.unlock_cnt == wdg_pkg::UNLOCK_LAST) begin
            nxt_st.unlock     = 1'b0;
            nxt_st.unlock_cnt = wdg_pkg::UNLOCK_NONE;
        end else if (st_ff.unlock) begin
            nxt_st.unlock_cnt = st_ff.unlock_cnt - wdg_pkg::UNLOCK_LAST;
        end

        // control register write, data phase
        if (st_ff.wr_ctl) begin
            if (wbyte[wdg_pkg::BIT_FLAG]) begin
                nxt_st.flag = 1'b0;
            end
            nxt_st.ie = wbyte[wdg_pkg::BIT_IE];
            if (unlock_start) begin
                nxt_st.unlock     = 1'b1;
                nxt_st.unlock_cnt = wdg_pkg::UNLOCK_CYCLES;
                nxt_st.re         = 1'b1;
            end else if (unlock_write) begin
                // only inside the window may reset enable drop or period move
                nxt_st.re         = wbyte[wdg_pkg::BIT_RE];
                nxt_st.psel       = {wbyte[wdg_pkg::BIT_P3], wbyte[wdg_pkg::BIT_P2:wdg_pkg::BIT_P0]};
                nxt_st.unlock     = 1'b0;
                nxt_st.unlock_cnt = wdg_pkg::UNLOCK_NONE;
            end else if (wbyte[wdg_pkg::BIT_RE]) begin
                nxt_st.re = 1'b1;
            end
        end

        // reset-cause register: writing zero clears the flag
        if (st_ff.wr_cause & ~wbyte[wdg_pkg::BIT_WATCHDOG_CAUSED_RESET_FLAG]) begin
            nxt_st.watchdog_caused_reset_flag = 1'b0;
        end

        // vector execution; combined mode falls back to reset mode
        if (vector_ack) begin
            nxt_st.flag = 1'b0;
            if (re_eff) begin
                nxt_st.ie = 1'b0;
            end
        end

        // counter
        if (restart_req | ~running) begin
            nxt_st.cnt = wdg_pkg::CNT_ZERO;
        end else if (expire) begin
            nxt_st.cnt = wdg_pkg::CNT_ZERO;
        end else if (tick) begin
            nxt_st.cnt = st_ff.cnt + wdg_pkg::CNT_ONE;
        end

        // expiry: set wins over any clear in the same cycle
        if (expire) begin
            if (ie_eff & ~(re_eff & st_ff.flag)) begin
                nxt_st.flag = 1'b1;
            end else if (re_eff) begin
                nxt_st.sysrst = 1'b1;
                nxt_st.watchdog_caused_reset_flag   = 1'b1;
            end
        end

        nxt_st.irq = st_ff.flag & ie_eff & global_irq_en;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_ff <= '{flag: 1'b0, ie: 1'b0, re: 1'b0, psel: wdg_pkg::PSEL_RST,
                       unlock: 1'b0, unlock_cnt: wdg_pkg::UNLOCK_NONE, watchdog_caused_reset_flag: 1'b0,
                       cnt: wdg_pkg::CNT_ZERO, osc_q: 1'b0, irq: 1'b0, sysrst: 1'b0,
                       wr_ctl: 1'b0, wr_cause: 1'b0, hrdata: wdg_pkg::RDATA_ZERO,
                       hready: 1'b1};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign hrdata       = st_ff.hrdata;
    assign hreadyout    = st_ff.hready;
    assign hresp        = 1'b0;
    assign timeout_irq  = st_ff.irq;
    assign system_reset = st_ff.sysrst;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_unlock_open;
        st_ff.wr_ctl && wbyte[wdg_pkg::BIT_CE] && wbyte[wdg_pkg::BIT_RE];
    endsequence

    // a settings write closes the window early, so only untouched windows are timed
    sequence s_window_quiet;
        !st_ff.wr_ctl [*4];
    endsequence

    a_unlock_window: assert property (
        s_unlock_open ##1 s_window_quiet |-> (st_ff.unlock && $past(st_ff.unlock, 3)) ##1 !st_ff.unlock)
        else $error("unlock window length wrong");

    a_period_locked: assert property (
        (st_ff.wr_ctl && !st_ff.unlock) |=> st_ff.psel == $past(st_ff.psel))
        else $error("period changed outside unlock window");

    a_fuse_forces: assert property (
        (always_on_fuse && addr_ok && !hwrite && haddr == wdg_pkg::ADDR_CTL)
        |=> (hrdata[wdg_pkg::BIT_RE] && !hrdata[wdg_pkg::BIT_IE]))
        else $error("fuse did not force reset mode view");

    a_cause_holds: assert property (
        (st_ff.watchdog_caused_reset_flag && addr_ok && !hwrite && haddr == wdg_pkg::ADDR_CTL)
        |=> hrdata[wdg_pkg::BIT_RE])
        else $error("reset enable low while cause flag set");

    a_restart_zero: assert property (
        restart_req |=> st_ff.cnt == wdg_pkg::CNT_ZERO)
        else $error("restart did not clear counter");

    a_irq_expiry: assert property (
        (expire && ie_eff && !re_eff) |=> (st_ff.flag && !system_reset))
        else $error("interrupt mode expiry wrong");

    a_reset_pulse: assert property (
        (expire && re_eff && !ie_eff) |=> (system_reset && st_ff.watchdog_caused_reset_flag) ##1 !system_reset)
        else $error("reset mode expiry wrong");

    a_combined_second: assert property (
        (expire && ie_eff && re_eff && st_ff.flag) |=> system_reset)
        else $error("combined mode second expiry did not reset");

    a_vector_clears: assert property (
        (vector_ack && !expire && re_eff) |=> (!st_ff.flag && !st_ff.ie))
        else $error("vector did not clear flag and enable");

    a_irq_gate: assert property (
        timeout_irq |-> $past(st_ff.flag && ie_eff && global_irq_en))
        else $error("interrupt without flag and enables");

    a_flag_w1c: assert property (
        (st_ff.wr_ctl && !wbyte[wdg_pkg::BIT_FLAG] && st_ff.flag && !vector_ack) |=> st_ff.flag)
        else $error("writing zero cleared the flag");

endmodule

`default_nettype wire
